// *** rtl/wol_params.svh ***
// offsets, field positions, reset values and timing counts of the wake detector
`ifndef WOL_PARAMS_SVH
`define WOL_PARAMS_SVH
// register indices, byte address is four times the index
`define CFG_IDX 10'h134
`define STS_IDX 10'h135
`define MACH_IDX 10'h136
`define MACL_IDX 10'h137
`define PWH_IDX 10'h138
`define PWL_IDX 10'h139
`define ISTS_IDX 10'h13A
`define IMSK_IDX 10'h13B
`define PAT_IDX 10'h140
// config fields
`define CFG_MAGIC 0
`define CFG_PAT 1
`define CFG_PASS 2
`define CFG_BCAST 3
`define CFG_UCAST 4
`define CFG_GPIO 5
`define CFG_LEVEL 6
// event bits, shared by status, interrupt status and mask
`define EVT_MAGIC 0
`define EVT_PAT 1
`define EVT_CRC 2
`define EVT_W 3
// reset values
`define CFG_RST 16'h0000
`define MASK_RST 3'h0
`define MAC_RST 48'h0000_0000_0000
// frame format
`define SYNC_BYTE 8'hFF
`define SYNC_LEN 3'h6
`define LAST_BYTE 3'h5
`define LAST_COPY 4'hF
`define PAT_LEN 7'h40
// gpio pulse length
`define CLK_NS 25
`define PULSE_NS 200
`define PULSE_CYC ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// *** rtl/wol_pkg.sv ***
// types of the wake frame detector
package wol_pkg;
    typedef enum logic [1:0] {MS_SYNC, MS_ADDR, MS_PASS} magic_state_t;
    typedef logic [7:0] byte_t;
endpackage : wol_pkg

// *** rtl/wol_magic_match.sv ***
// sync run, sixteen address copies and optional password matcher
`timescale 1ns/1ps
`include "wol_params.svh"
module wol_magic_match
    import wol_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // receive byte stream
    input  wire logic        frame_start,
    input  wire logic        byte_vld,
    input  wire byte_t       byte_in,
    // settings
    input  wire logic [47:0] addr,
    input  wire logic [47:0] pass,
    input  wire logic        pass_en,
    // result, held until the next frame
    output logic             hit
);
    magic_state_t state_ff;
    logic [2:0]   sync_ff;
    logic [2:0]   idx_ff;
    logic [3:0]   copy_ff;
    logic         hit_ff;
    byte_t        want;

    // first byte on the wire is the top byte of the vector
    function automatic byte_t pick_byte(input logic [47:0] v, input logic [2:0] i);
        pick_byte = v[6'd40 - {i, 3'b000} +: 8];
    endfunction : pick_byte

    assign want = (state_ff == MS_PASS) ? pick_byte(pass, idx_ff)
                                        : pick_byte(addr, idx_ff); // RL15
    assign hit  = hit_ff;

    // scan every byte, so the sequence may start anywhere
    always_ff @(posedge clk) begin
        if (rst || frame_start) begin
            state_ff <= MS_SYNC;
            sync_ff  <= 3'h0;
            idx_ff   <= 3'h0;
            copy_ff  <= 4'h0;
            hit_ff   <= 1'b0;
        end else if (byte_vld && !hit_ff) begin // RL6
            case (state_ff)
                MS_SYNC: begin
                    if (sync_ff == `SYNC_LEN && byte_in == pick_byte(addr, 3'h0)) begin // RL3
                        state_ff <= MS_ADDR;
                        idx_ff   <= 3'h1;
                        copy_ff  <= 4'h0;
                    end else if (byte_in == `SYNC_BYTE) begin
                        if (sync_ff != `SYNC_LEN)
                            sync_ff <= sync_ff + 3'h1;
                    end else begin
                        sync_ff <= 3'h0;
                    end
                end
                MS_ADDR, MS_PASS: begin
                    if (byte_in != want) begin
                        // restart the hunt, this byte may open a new run
                        state_ff <= MS_SYNC; // RL16
                        sync_ff  <= (byte_in == `SYNC_BYTE) ? 3'h1 : 3'h0;
                        idx_ff   <= 3'h0;
                    end else if (idx_ff != `LAST_BYTE) begin
                        idx_ff <= idx_ff + 3'h1;
                    end else begin
                        idx_ff <= 3'h0;
                        if (state_ff == MS_PASS) begin
                            hit_ff <= 1'b1; // RL15
                        end else if (copy_ff != `LAST_COPY) begin
                            copy_ff <= copy_ff + 4'h1; // RL4
                        end else if (pass_en) begin
                            state_ff <= MS_PASS; // RL5
                        end else begin
                            hit_ff <= 1'b1;
                        end
                    end
                end
                default: state_ff <= MS_SYNC;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sync_needed: assert property (state_ff == MS_SYNC && sync_ff != `SYNC_LEN // RL3
        && !frame_start |=> state_ff == MS_SYNC)
        else $error("address phase entered without full sync run");
    a_copies_count: assert property ($rose(state_ff == MS_PASS) // RL4
        |-> $past(copy_ff) == `LAST_COPY && $past(idx_ff) == `LAST_BYTE)
        else $error("password phase before sixteenth copy");
    a_pass_required: assert property ($rose(hit_ff) && pass_en // RL5
        |-> $past(state_ff) == MS_PASS) else $error("hit without password");
    a_mismatch_drop: assert property (state_ff == MS_ADDR && byte_vld && byte_in != want // RL16
        && !hit_ff && !frame_start |=> state_ff == MS_SYNC && !hit_ff)
        else $error("partial match kept after mismatch");
endmodule : wol_magic_match

// *** rtl/wol_pattern_match.sv ***
// compares the first bytes of a frame against the stored custom pattern
`timescale 1ns/1ps
`include "wol_params.svh"
module wol_pattern_match
    import wol_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // receive byte stream
    input  wire logic         frame_start,
    input  wire logic         byte_vld,
    input  wire byte_t        byte_in,
    // pattern, byte 0 in the low bits
    input  wire logic [511:0] pattern,
    // result, held until the next frame
    output logic              hit
);
    logic [6:0] pos_ff;
    logic       bad_ff;
    logic       hit_ff;
    logic       same;

    assign same = byte_in == pattern[{pos_ff[5:0], 3'b000} +: 8];
    assign hit  = hit_ff;

    // one compare per byte keeps the logic to a single byte lane
    always_ff @(posedge clk) begin
        if (rst || frame_start) begin
            pos_ff <= 7'h0;
            bad_ff <= 1'b0;
            hit_ff <= 1'b0;
        end else if (byte_vld && pos_ff != `PAT_LEN) begin
            pos_ff <= pos_ff + 7'h1;
            if (!same)
                bad_ff <= 1'b1;
            if (pos_ff == `PAT_LEN - 7'h1 && !bad_ff && same)
                hit_ff <= 1'b1; // RL12
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pat_full_len: assert property ($rose(hit_ff) |-> pos_ff == `PAT_LEN && !bad_ff) // RL12
        else $error("pattern hit before all bytes compared");
endmodule : wol_pattern_match

// *** rtl/wol_frame_detect.sv ***
// wake frame detector: apb registers, destination filter, event and gpio logic
// Function
// [RL1] with wake mode on, scan frames for this node, ignore other destinations
// [RL2] destination may be the station address or broadcast
// [RL3] sequence begins only after six consecutive all-ones bytes
// [RL4] station address must then repeat sixteen times back to back
// [RL5] with password on, password bytes must follow the sixteenth copy
// [RL6] sequence may start at any byte position of the frame
// [RL7] sender keeps the sequence byte aligned
// [RL8] bad frame check sequence suppresses the wake event
// [RL9] wake drives a chosen gpio pulse or level, or interrupt flag
// [RL10] each wake event shows in a readable status register
// [RL11] detection works at 10, 100 and 1000 Mb/s
// [RL12] one 64-byte software pattern wakes like a standard wake frame
// [RL13] broadcast and unicast wake have independent enables
// [RL14] options at config offset 134h, results at status offset 135h
// [RL15] six password bytes compared in order after the sixteenth copy
// [RL16] a mismatch drops the partial match and hunts a new sync run
// [RL17] wake status stays set until software clears it
`timescale 1ns/1ps
`include "wol_params.svh"
module wol_frame_detect
    import wol_pkg::*;
#(
    // gpio pulse length in core clocks
    parameter int PULSE_CYCLES = `PULSE_CYC
)
(
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // receive byte stream, one byte per strobe at any line speed
    input  wire logic        RX_FRAME_START,
    input  wire logic        RX_BYTE_VALID,
    input  wire byte_t       RX_BYTE,
    input  wire logic        RX_FRAME_END,
    input  wire logic        RX_FCS_OK,
    // wake outputs
    output logic             WAKE_GPIO,
    output logic             WAKE_IRQ
);
    // software registers
    logic [15:0]        cfg_ff;
    logic [47:0]        mac_ff;
    logic [47:0]        pass_ff;
    logic [511:0]       pat_ff;
    logic [`EVT_W-1:0]  mask_ff;

    // event status
    logic [`EVT_W-1:0]  evt_ff;
    logic [`EVT_W-1:0]  nxt_evt;
    logic [`EVT_W-1:0]  evt_set;
    logic [`EVT_W-1:0]  evt_clr;

    // read path
    logic [31:0]        prdata_ff;
    logic [31:0]        nxt_prdata;

    // stream side
    logic [2:0]         hdr_ff;
    logic               uc_ok_ff;
    logic               bc_ok_ff;
    logic [3:0]         pulse_ff;
    logic               gpio_ff;
    logic               irq_ff;

    // decode and match results
    logic [9:0]         idx;
    logic               mapped;
    logic               wr;
    logic               magic_hit;
    logic               pat_hit;
    logic               dest_ok;
    logic               cand_magic;
    logic               cand_pat;
    logic               wake;

    // no wait states are ever inserted
    assign idx    = PADDR[11:2];
    assign wr     = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign PRDATA = prdata_ff;

    // byte-wide stream decouples detection from line speed
    wol_magic_match u_magic ( // RL11
        .clk         (CORE_CLK),
        .rst         (RST),
        .frame_start (RX_FRAME_START),
        .byte_vld    (RX_BYTE_VALID),
        .byte_in     (RX_BYTE),
        .addr        (mac_ff),
        .pass        (pass_ff),
        .pass_en     (cfg_ff[`CFG_PASS]),
        .hit         (magic_hit)
    );

    // custom pattern compare
    wol_pattern_match u_pattern (
        .clk         (CORE_CLK),
        .rst         (RST),
        .frame_start (RX_FRAME_START),
        .byte_vld    (RX_BYTE_VALID),
        .byte_in     (RX_BYTE),
        .pattern     (pat_ff),
        .hit         (pat_hit)
    );

    // address decode, indices times four give the byte addresses
    always_comb begin
        mapped     = 1'b1;
        nxt_prdata = 32'h0000_0000;
        if (idx == `CFG_IDX) begin // RL14
            nxt_prdata[15:0] = cfg_ff;
        end else if (idx == `STS_IDX) begin // RL14
            nxt_prdata[`EVT_W-1:0] = evt_ff; // RL10
        end else if (idx == `MACH_IDX) begin
            nxt_prdata[15:0] = mac_ff[47:32];
        end else if (idx == `MACL_IDX) begin
            nxt_prdata = mac_ff[31:0];
        end else if (idx == `PWH_IDX) begin
            nxt_prdata[15:0] = pass_ff[47:32];
        end else if (idx == `PWL_IDX) begin
            nxt_prdata = pass_ff[31:0];
        end else if (idx == `ISTS_IDX) begin
            nxt_prdata[`EVT_W-1:0] = evt_ff;
        end else if (idx == `IMSK_IDX) begin
            nxt_prdata[`EVT_W-1:0] = mask_ff;
        end else if (idx[9:4] == `PAT_IDX >> 4) begin
            nxt_prdata = pat_ff[{idx[3:0], 5'b00000} +: 32];
        end else begin
            mapped = 1'b0;
        end
    end

    // unmapped access ends with an error, reads give zero
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // read data captured in the setup cycle, stable through access
    always_ff @(posedge CORE_CLK) begin
        if (RST)
            prdata_ff <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !PWRITE)
            prdata_ff <= nxt_prdata;
    end

    // configuration and pattern writes
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cfg_ff  <= `CFG_RST;
            mac_ff  <= `MAC_RST;
            pass_ff <= `MAC_RST;
            mask_ff <= `MASK_RST;
            pat_ff  <= '0;
        end else if (wr) begin
            // status is read only
            if (idx == `CFG_IDX)
                cfg_ff <= PWDATA[15:0]; // RL14
            else if (idx == `MACH_IDX)
                mac_ff[47:32] <= PWDATA[15:0];
            else if (idx == `MACL_IDX)
                mac_ff[31:0] <= PWDATA;
            else if (idx == `PWH_IDX)
                pass_ff[47:32] <= PWDATA[15:0];
            else if (idx == `PWL_IDX)
                pass_ff[31:0] <= PWDATA;
            else if (idx == `IMSK_IDX)
                mask_ff <= PWDATA[`EVT_W-1:0];
            else if (idx[9:4] == `PAT_IDX >> 4)
                pat_ff[{idx[3:0], 5'b00000} +: 32] <= PWDATA; // RL12
        end
    end

    // destination filter over the first six bytes of each frame
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            hdr_ff   <= 3'h0;
            uc_ok_ff <= 1'b0;
            bc_ok_ff <= 1'b0;
        end else if (RX_FRAME_START) begin
            hdr_ff   <= 3'h0;
            uc_ok_ff <= 1'b1;
            bc_ok_ff <= 1'b1;
        end else if (RX_BYTE_VALID && hdr_ff != `SYNC_LEN) begin
            // one wrong byte closes the gate
            hdr_ff <= hdr_ff + 3'h1;
            if (RX_BYTE != mac_ff[6'd40 - {hdr_ff, 3'b000} +: 8])
                uc_ok_ff <= 1'b0; // RL2
            if (RX_BYTE != `SYNC_BYTE)
                bc_ok_ff <= 1'b0; // RL2
        end
    end

    // short frames never reach a full destination field
    assign dest_ok = hdr_ff == `SYNC_LEN
                     && ((uc_ok_ff && cfg_ff[`CFG_UCAST])
                      || (bc_ok_ff && cfg_ff[`CFG_BCAST])); // RL13
    assign cand_magic = cfg_ff[`CFG_MAGIC] && magic_hit && dest_ok; // RL1
    assign cand_pat   = cfg_ff[`CFG_PAT] && pat_hit && dest_ok;
    // wake needs a good check sequence
    assign wake       = RX_FRAME_END && RX_FCS_OK && (cand_magic || cand_pat);

    // events are judged at frame end, once the check sequence is known
    always_comb begin
        evt_set = '0;
        if (RX_FRAME_END) begin
            if (RX_FCS_OK) begin // RL8
                evt_set[`EVT_MAGIC] = cand_magic;
                evt_set[`EVT_PAT]   = cand_pat;
            end else begin
                evt_set[`EVT_CRC] = cand_magic || cand_pat;
            end
        end
        // write ones to clear
        evt_clr = (wr && idx == `ISTS_IDX) ? PWDATA[`EVT_W-1:0] : '0;
    end

    // a new event wins over a clear in the same cycle
    assign nxt_evt = (evt_ff & ~evt_clr) | evt_set;

    // sticky status, cleared by writing ones
    always_ff @(posedge CORE_CLK) begin
        if (RST)
            evt_ff <= '0;
        else
            evt_ff <= nxt_evt; // RL17
    end

    // gpio pulse length counter
    // a new wake restarts the count
    always_ff @(posedge CORE_CLK) begin
        if (RST)
            pulse_ff <= 4'h0;
        else if (wake)
            pulse_ff <= 4'(PULSE_CYCLES); // RL9
        else if (pulse_ff != 4'h0)
            pulse_ff <= pulse_ff - 4'h1;
    end

    // level mode holds until software clears the wake bits
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            gpio_ff <= 1'b0;
            irq_ff  <= 1'b0;
        end else begin
            // level mode ignores the counter
            gpio_ff <= cfg_ff[`CFG_GPIO]
                       && (cfg_ff[`CFG_LEVEL] ? |nxt_evt[`EVT_PAT:`EVT_MAGIC]
                                             : (wake || pulse_ff > 4'h1)); // RL9
            irq_ff  <= |(nxt_evt & mask_ff); // RL9
        end
    end

    // pins come straight from flip-flops
    assign WAKE_GPIO = gpio_ff;
    assign WAKE_IRQ  = irq_ff;

    // checks, all on the core clock
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_dest_gate: assert property (RX_FRAME_END && !dest_ok // RL1
        |=> !(evt_ff[`EVT_MAGIC] && !$past(evt_ff[`EVT_MAGIC]))
         && !(evt_ff[`EVT_PAT] && !$past(evt_ff[`EVT_PAT])))
        else $error("wake from frame for another node");

    a_fcs_block: assert property (RX_FRAME_END && !RX_FCS_OK // RL8
        |=> !(evt_ff[`EVT_MAGIC] && !$past(evt_ff[`EVT_MAGIC])))
        else $error("wake despite bad check sequence");

    a_crc_flag: assert property (RX_FRAME_END && !RX_FCS_OK && cand_magic // RL8
        |=> evt_ff[`EVT_CRC]) else $error("bad check sequence not flagged");

    a_pat_wake: assert property (RX_FRAME_END && RX_FCS_OK && cand_pat // RL12
        |=> evt_ff[`EVT_PAT]) else $error("pattern wake not shown in status");

    a_wake_status: assert property (RX_FRAME_END && RX_FCS_OK && cand_magic // RL10
        |=> evt_ff[`EVT_MAGIC]) else $error("wake not shown in status");

    a_status_sticky: assert property (evt_ff[`EVT_MAGIC] // RL17
        && !(wr && idx == `ISTS_IDX && PWDATA[`EVT_MAGIC])
        |=> evt_ff[`EVT_MAGIC]) else $error("wake status lost without clear");

    a_gpio_pulse: assert property (wake && cfg_ff[`CFG_GPIO] && !cfg_ff[`CFG_LEVEL] // RL9
        && !wr |=> WAKE_GPIO [*2]) else $error("gpio pulse too short");

    a_pulse_end: assert property ( // RL9
        !wake && !cfg_ff[`CFG_LEVEL] && pulse_ff == 4'h1
        |=> !WAKE_GPIO) else $error("gpio pulse too long");

    a_irq_level: assert property ( // RL9
        !$past(wr) |-> WAKE_IRQ == |(evt_ff & mask_ff))
        else $error("interrupt differs from masked status");
endmodule : wol_frame_detect

// *** verification/wol_rx_source.sv ***
// receive byte source standing in for the phy receive path
`timescale 1ns/1ps
module wol_rx_source
    import wol_pkg::*;
(
    // clock
    input  wire logic clk,
    // receive byte stream
    output logic      frame_start,
    output logic      byte_vld,
    output byte_t     byte_out,
    output logic      frame_end,
    output logic      fcs_ok
);
    // idle levels at time zero
    initial begin
        frame_start = 1'b0;
        byte_vld = 1'b0;
        byte_out = 8'h5a;
        frame_end = 1'b0;
        fcs_ok = 1'b0;
    end

    // one frame: start pulse, bytes with optional gaps, end pulse with crc verdict
    task automatic send(input byte_t fr[$], input logic good, input logic slow);
        int i;
        @(posedge clk);
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        for (i = 0; i < fr.size(); i++) begin
            byte_vld <= 1'b1;
            byte_out <= fr[i];
            @(posedge clk);
            if (slow && (i % 4) != 0) begin
                // a gap models a slower line; stale data is inverted, never held
                byte_vld <= 1'b0;
                byte_out <= ~fr[i];
                repeat (i % 4) @(posedge clk);
            end
        end
        byte_vld <= 1'b0;
        byte_out <= 8'ha5;
        frame_end <= 1'b1;
        fcs_ok <= good;
        @(posedge clk);
        frame_end <= 1'b0;
        fcs_ok <= ~good;
    endtask : send
endmodule : wol_rx_source

// *** verification/wol_frame_detect_tb_top.sv ***
// self-checking bench of the wake frame detector
`timescale 1ns/1ps
`include "wol_params.svh"
module wol_frame_detect_tb_top
    import wol_pkg::*;
;
    logic        core_clk;
    logic        rst;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_start;
    logic        rx_vld;
    byte_t       rx_byte;
    logic        rx_end;
    logic        rx_fcs;
    logic        wake_gpio;
    logic        wake_irq;
    int          n_mismatch = 0;
    int          total_checks = 0;
    logic [32:0] exp_q[$];
    byte_t       fr[$];
    byte_t       pat[64];
    logic [31:0] rnd;
    logic [47:0] mac;
    logic [47:0] pw;
    logic [15:0] cfg;
    logic        slow = 1'b0;
    int          i;

    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // short gpio pulse keeps the run brief
    wol_frame_detect #(.PULSE_CYCLES(2)) i_wol_frame_detect (
        .CORE_CLK(core_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RX_FRAME_START(rx_start),
        .RX_BYTE_VALID(rx_vld), .RX_BYTE(rx_byte), .RX_FRAME_END(rx_end),
        .RX_FCS_OK(rx_fcs), .WAKE_GPIO(wake_gpio), .WAKE_IRQ(wake_irq));

    wol_rx_source i_wol_rx_source (
        .clk(core_clk), .frame_start(rx_start), .byte_vld(rx_vld),
        .byte_out(rx_byte), .frame_end(rx_end), .fcs_ok(rx_fcs));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // random byte that can never extend a sync run
    function automatic byte_t nb();
        rnd = xs(rnd);
        return rnd[7:0] & 8'hfe;
    endfunction : nb

    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction : ba

    task automatic print_verdict();
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; the wait for pready is bounded
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            n_mismatch++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic wcfg();
        wr(ba(`CFG_IDX), {16'h0000, cfg});
        rd(ba(`CFG_IDX), {17'h0_0000, cfg});
    endtask : wcfg

    // read watcher: each completed read is paired with the oldest note
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1_ffff_ffff);
            else chk({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // frame builders; an address goes out first byte from the top bits
    task automatic put_mac(input logic [47:0] m, input int n);
        int k;
        for (k = 0; k < 6 * n; k++) fr.push_back(m[47 - 8 * (k % 6) -: 8]);
    endtask : put_mac

    task automatic put_ff(input int n);
        repeat (n) fr.push_back(8'hff);
    endtask : put_ff

    task automatic put_rnd(input int n);
        repeat (n) fr.push_back(nb());
    endtask : put_rnd

    task automatic hdr(input logic [47:0] dest);
        put_mac(dest, 1);
        put_rnd(8);
    endtask : hdr

    // send the built frame, check outputs and status, then clear the events
    task automatic run(input logic good, input logic [2:0] evt, input logic irq,
                       input logic g, input logic gl);
        slow = ~slow;
        i_wol_rx_source.send(fr, good, slow);
        @(posedge core_clk);
        #1;
        chk({32'h0, wake_irq}, {32'h0, irq});
        chk({32'h0, wake_gpio}, {32'h0, g});
        rd(ba(`STS_IDX), {30'h0, evt});
        rd(ba(`ISTS_IDX), {30'h0, evt});
        #1;
        chk({32'h0, wake_gpio}, {32'h0, gl});
        wr(ba(`ISTS_IDX), 32'h0000_0007);
        @(posedge core_clk);
        #1;
        chk({32'h0, wake_irq | wake_gpio}, 33'h0);
        fr.delete();
    endtask : run

    // main sequence
    initial begin
        rst = 1'b1;
        rnd = 32'hf14c_a20e;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        chk({31'h0, wake_irq, wake_gpio}, 33'h0);
        // reset values and refused accesses
        rd(ba(`CFG_IDX), 33'h0);
        rd(ba(`MACH_IDX), 33'h0);
        rd(ba(`IMSK_IDX), 33'h0);
        rd(12'h7f0, 33'h1_0000_0000);
        wr(ba(`STS_IDX), 32'h0000_ffff);
        rd(ba(`STS_IDX), 33'h0);
        mac = {nb(), nb(), nb(), nb(), nb(), nb()};
        pw = {nb(), nb(), nb(), nb(), nb(), nb()};
        wr(ba(`MACH_IDX), {16'h0000, mac[47:32]});
        wr(ba(`MACL_IDX), mac[31:0]);
        wr(ba(`PWH_IDX), {16'h0000, pw[47:32]});
        wr(ba(`PWL_IDX), pw[31:0]);
        wr(ba(`IMSK_IDX), 32'h0000_0007);
        rd(ba(`MACL_IDX), {1'b0, mac[31:0]});
        cfg = 16'h0000;
        cfg[`CFG_MAGIC] = 1'b1;
        cfg[`CFG_UCAST] = 1'b1;
        cfg[`CFG_GPIO] = 1'b1;
        wcfg();
        // unicast wake frame, sequence deep in the payload
        hdr(mac); put_rnd(5); put_ff(6); put_mac(mac, 16); put_rnd(4);
        run(1'b1, 3'h1, 1'b1, 1'b1, 1'b0);
        hdr(mac ^ 48'h1); put_ff(6); put_mac(mac, 16);
        run(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
        hdr({6{8'hff}}); put_ff(6); put_mac(mac, 16);
        run(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
        cfg[`CFG_BCAST] = 1'b1;
        cfg[`CFG_UCAST] = 1'b0;
        wcfg();
        hdr({6{8'hff}}); put_ff(6); put_mac(mac, 16);
        run(1'b1, 3'h1, 1'b1, 1'b1, 1'b0);
        hdr(mac); put_ff(6); put_mac(mac, 16);
        run(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
        cfg[`CFG_UCAST] = 1'b1;
        wcfg();
        hdr(mac); put_ff(6); put_mac(mac, 16);
        run(1'b0, 3'h4, 1'b1, 1'b0, 1'b0);
        hdr(mac); put_ff(5); put_mac(mac, 16);
        run(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
        hdr(mac); put_ff(6); put_mac(mac, 15); put_rnd(6);
        run(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
        hdr(mac); put_ff(6); put_mac(mac, 5); put_rnd(1); put_ff(6); put_mac(mac, 16);
        run(1'b1, 3'h1, 1'b1, 1'b1, 1'b0);
        // password required after the sixteenth copy
        cfg[`CFG_PASS] = 1'b1;
        wcfg();
        hdr(mac); put_ff(6); put_mac(mac, 16); put_mac(pw, 1);
        run(1'b1, 3'h1, 1'b1, 1'b1, 1'b0);
        hdr(mac); put_ff(6); put_mac(mac, 16); put_mac(pw ^ 48'h1, 1);
        run(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
        hdr(mac); put_ff(6); put_mac(mac, 16); put_rnd(6);
        run(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
        // masked event still latches status but keeps the interrupt low
        cfg[`CFG_PASS] = 1'b0;
        wcfg();
        wr(ba(`IMSK_IDX), 32'h0000_0006);
        hdr(mac); put_ff(6); put_mac(mac, 16);
        run(1'b1, 3'h1, 1'b0, 1'b1, 1'b0);
        wr(ba(`IMSK_IDX), 32'h0000_0007);
        // custom pattern with level gpio
        for (i = 0; i < 64; i++) pat[i] = (i < 6) ? mac[47 - 8 * i -: 8] : nb();
        for (i = 0; i < 16; i++)
            wr(ba(10'(`PAT_IDX + i)), {pat[4*i+3], pat[4*i+2], pat[4*i+1], pat[4*i]});
        cfg = 16'h0000;
        cfg[`CFG_PAT] = 1'b1;
        cfg[`CFG_UCAST] = 1'b1;
        cfg[`CFG_GPIO] = 1'b1;
        cfg[`CFG_LEVEL] = 1'b1;
        wcfg();
        for (i = 0; i < 64; i++) fr.push_back(pat[i]);
        put_rnd(8);
        run(1'b1, 3'h2, 1'b1, 1'b1, 1'b1);
        for (i = 0; i < 64; i++) fr.push_back(pat[i]);
        fr[63] = fr[63] ^ 8'h01;
        run(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge core_clk);
        if (exp_q.size() != 0) n_mismatch++;
        print_verdict();
    end

    // run limit in case a transfer never completes
    initial begin
        #2_000_000;
        n_mismatch++;
        print_verdict();
    end
endmodule : wol_frame_detect_tb_top
